/* File: fps_pkg.sv */
package fps_pkg;
    localparam int FPS_CLK_HZ = 10000000;
    localparam int FPS_ADDR_W = 9;
    localparam int FPS_DATA_W = 8;
    localparam int FPS_NS_PER_CLK = 1000000000 / FPS_CLK_HZ;
    // times in microseconds
    localparam int FPS_RISE_US = 10;
    localparam int FPS_DELAY_MIN_US = 10;
    localparam int FPS_PULSE_US = 100;
    localparam int FPS_TOTAL_US = 1000;
    localparam int FPS_SETTLE_US = 1;
    // least times round up to whole cycles
    localparam int FPS_RISE_CYC = (FPS_RISE_US * 1000 + FPS_NS_PER_CLK - 1) / FPS_NS_PER_CLK;
    localparam int FPS_DELAY_CYC =
        (FPS_DELAY_MIN_US * 1000 + FPS_NS_PER_CLK - 1) / FPS_NS_PER_CLK;
    localparam int FPS_PULSE_CYC = (FPS_PULSE_US * 1000 + FPS_NS_PER_CLK - 1) / FPS_NS_PER_CLK;
    localparam int FPS_SETTLE_CYC =
        (FPS_SETTLE_US * 1000 + FPS_NS_PER_CLK - 1) / FPS_NS_PER_CLK;
    localparam int FPS_MAX_PULSES = FPS_TOTAL_US / FPS_PULSE_US;
    localparam int FPS_TIMER_W = 16;
    localparam int FPS_CNT_W = 4;

    typedef enum logic [1:0] {
        FPS_SUPPLY_VERIFY,
        FPS_SUPPLY_PROGRAM
    } fps_supply_e;

    typedef struct packed {
        logic [FPS_ADDR_W-1:0] addr;
        logic [FPS_DATA_W-1:0] data;
    } fps_word_s;

    typedef struct packed {
        logic [FPS_ADDR_W-1:0] addr;
        logic [FPS_DATA_W-1:0] desired;
        logic [FPS_DATA_W-1:0] actual;
    } fps_result_s;
endpackage

/* File: fps_programmer.sv */
// Operation
// - each word starts with its binary address driven firmly on the address pins.
// - chip select is driven high and held there through the whole programming phase.
// - before the supply rises every output is left undriven, below the disable level.
// - the supply is raised to the programming level with a controlled rise time.
// - after the supply is up, at least the programming delay passes before any pulse.
// - one bit is programmed by a single enable pulse of 100 to 1000 us on its output.
// - further bits of the word are pulsed in turn, at least one delay apart.
// - one delay after the last pulse the supply is lowered to the verify level.
// - after lowering the supply chip select goes low and the word is read back.
// - failing bits are retried until they have had 1.0 ms of pulses, then rejected.
// - the total pulse time may be split into shorter pulses within the cumulative limit.
// - the sequence is repeated for every word that has bits to program.
module fps_programmer #(
    parameter int ADDR_W = fps_pkg::FPS_ADDR_W,
    parameter int DATA_W = fps_pkg::FPS_DATA_W,
    parameter int RISE_CYC = fps_pkg::FPS_RISE_CYC,
    parameter int DELAY_CYC = fps_pkg::FPS_DELAY_CYC,
    parameter int PULSE_CYC = fps_pkg::FPS_PULSE_CYC,
    parameter int MAX_PULSES = fps_pkg::FPS_MAX_PULSES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic reqValid,
    output logic reqReady,
    input wire fps_pkg::fps_word_s reqWord,
    output logic doneValid,
    output logic donePass,
    output fps_pkg::fps_result_s doneResult,
    output logic [ADDR_W-1:0] promAddr,
    output logic promSelect,
    output fps_pkg::fps_supply_e supplyLevel,
    output logic [DATA_W-1:0] promDataOut,
    output logic [DATA_W-1:0] promDataOe,
    input wire logic [DATA_W-1:0] promDataIn
);
    import fps_pkg::*;

    typedef enum logic [3:0] {
        IDLE, SETUP, RISE, WAITD, PULSE, GAP, FALL, SETTLE, CHECK
    } fps_state_e;

    logic rstMeta, rstSync;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    fps_state_e state_reg, state_next;
    logic [FPS_TIMER_W-1:0] timer_reg, timer_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] want_reg, want_next;
    logic [DATA_W-1:0] todo_reg, todo_next;
    logic [$clog2(DATA_W)-1:0] bit_reg, bit_next;
    logic [FPS_CNT_W-1:0] pass_reg, pass_next;
    logic sel_reg, sel_next;
    logic hv_reg, hv_next;
    logic [DATA_W-1:0] oe_reg, oe_next;
    logic dv_reg, dv_next;
    logic dp_reg, dp_next;
    logic [DATA_W-1:0] act_reg, act_next;
    logic [DATA_W-1:0] pend;
    logic [DATA_W-1:0] lowMask;
    logic anyPend;

    // pending bits at or above the current one, lowest first
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_mask
            assign lowMask[gi] = (gi >= int'(bit_reg));
        end
    endgenerate
    assign pend = todo_reg & lowMask;
    assign anyPend = |pend;

    function automatic logic [$clog2(DATA_W)-1:0] firstSet(input logic [DATA_W-1:0] v);
        logic [$clog2(DATA_W)-1:0] r;
        r = '0;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[$clog2(DATA_W)-1:0];
            end
        end
        return r;
    endfunction

    always_comb begin
        state_next = state_reg;
        timer_next = (timer_reg != '0) ? timer_reg - 1'b1 : timer_reg;
        addr_next = addr_reg;
        want_next = want_reg;
        todo_next = todo_reg;
        bit_next = bit_reg;
        pass_next = pass_reg;
        sel_next = sel_reg;
        hv_next = hv_reg;
        oe_next = oe_reg;
        dv_next = 1'b0;
        dp_next = dp_reg;
        act_next = act_reg;
        unique case (state_reg)
            IDLE: begin
                if (reqValid) begin
                    addr_next = reqWord.addr;
                    want_next = reqWord.data;
                    todo_next = ~reqWord.data;
                    pass_next = '0;
                    if (reqWord.data == {DATA_W{1'b1}}) begin
                        state_next = SETTLE;
                        timer_next = FPS_TIMER_W'(FPS_SETTLE_CYC);
                        sel_next = 1'b0;
                    end else begin
                        state_next = SETUP;
                        sel_next = 1'b1;
                        timer_next = FPS_TIMER_W'(DELAY_CYC);
                    end
                end
            end
            SETUP: begin
                oe_next = '0;
                if (timer_reg == '0) begin
                    hv_next = 1'b1;
                    timer_next = FPS_TIMER_W'(RISE_CYC);
                    state_next = RISE;
                end
            end
            RISE: begin
                if (timer_reg == '0) begin
                    timer_next = FPS_TIMER_W'(DELAY_CYC);
                    bit_next = '0;
                    state_next = WAITD;
                end
            end
            WAITD: begin
                if (timer_reg == '0) begin
                    if (anyPend) begin
                        bit_next = firstSet(pend);
                        oe_next = '0;
                        oe_next[firstSet(pend)] = 1'b1;
                        timer_next = FPS_TIMER_W'(PULSE_CYC);
                        state_next = PULSE;
                    end else begin
                        hv_next = 1'b0;
                        timer_next = FPS_TIMER_W'(RISE_CYC);
                        state_next = FALL;
                    end
                end
            end
            PULSE: begin
                if (timer_reg == '0) begin
                    oe_next = '0;
                    timer_next = FPS_TIMER_W'(DELAY_CYC);
                    bit_next = bit_reg + 1'b1;
                    state_next = (int'(bit_reg) == DATA_W - 1) ? GAP : WAITD;
                end
            end
            GAP: begin
                // last bit pulsed: hold one delay then lower supply
                if (timer_reg == '0) begin
                    hv_next = 1'b0;
                    timer_next = FPS_TIMER_W'(RISE_CYC);
                    state_next = FALL;
                end
            end
            FALL: begin
                if (timer_reg == '0) begin
                    sel_next = 1'b0;
                    timer_next = FPS_TIMER_W'(FPS_SETTLE_CYC);
                    state_next = SETTLE;
                end
            end
            SETTLE: begin
                if (timer_reg == '0) begin
                    act_next = promDataIn;
                    state_next = CHECK;
                end
            end
            CHECK: begin
                // only zero bits still reading one are retried; a one read as zero is fatal
                todo_next = ~want_reg & act_reg;
                pass_next = pass_reg + 1'b1;
                if (act_reg == want_reg) begin
                    dv_next = 1'b1;
                    dp_next = 1'b1;
                    sel_next = 1'b1;
                    state_next = IDLE;
                end else if (((want_reg & ~act_reg) != '0) ||
                             (int'(pass_reg) + 1 >= MAX_PULSES)) begin
                    dv_next = 1'b1;
                    dp_next = 1'b0;
                    sel_next = 1'b1;
                    state_next = IDLE;
                end else begin
                    sel_next = 1'b1;
                    timer_next = FPS_TIMER_W'(DELAY_CYC);
                    state_next = SETUP;
                end
            end
            default: state_next = IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstSync) begin
        if (!rstSync) begin
            state_reg <= IDLE;
            timer_reg <= '0;
            addr_reg <= '0;
            want_reg <= '1;
            todo_reg <= '0;
            bit_reg <= '0;
            pass_reg <= '0;
            sel_reg <= 1'b1;
            hv_reg <= 1'b0;
            oe_reg <= '0;
            dv_reg <= 1'b0;
            dp_reg <= 1'b0;
            act_reg <= '1;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            addr_reg <= addr_next;
            want_reg <= want_next;
            todo_reg <= todo_next;
            bit_reg <= bit_next;
            pass_reg <= pass_next;
            sel_reg <= sel_next;
            hv_reg <= hv_next;
            oe_reg <= oe_next;
            dv_reg <= dv_next;
            dp_reg <= dp_next;
            act_reg <= act_next;
        end
    end

    assign reqReady = (state_reg == IDLE);
    assign doneValid = dv_reg;
    assign donePass = dp_reg;
    assign doneResult = '{addr: addr_reg, desired: want_reg, actual: act_reg};
    assign promAddr = addr_reg;
    assign promSelect = sel_reg;
    assign supplyLevel = hv_reg ? FPS_SUPPLY_PROGRAM : FPS_SUPPLY_VERIFY;
    // driven level is the program level; driver absent means disabled
    assign promDataOut = oe_reg;
    assign promDataOe = oe_reg;
endmodule

/* File: fps_checker.sv */
module fps_checker #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8,
    parameter int RISE_CYC = 2,
    parameter int DELAY_CYC = 3,
    parameter int PULSE_CYC = 5
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire fps_pkg::fps_word_s reqWord,
    input wire logic doneValid,
    input wire logic donePass,
    input wire fps_pkg::fps_result_s doneResult,
    input wire logic [ADDR_W-1:0] promAddr,
    input wire logic promSelect,
    input wire fps_pkg::fps_supply_e supplyLevel,
    input wire logic [DATA_W-1:0] promDataOut,
    input wire logic [DATA_W-1:0] promDataOe
);
    timeunit 1ns;
    timeprecision 1ns;
    import fps_pkg::*;
    logic [15:0] progCnt_reg, quietCnt_reg, pulseCnt_reg;
    logic [15:0] progCnt_next, quietCnt_next, pulseCnt_next;
    logic pulsing;
    // counters run from the sampled pins, so no design timer is trusted
    always_comb begin
        pulsing = |promDataOe;
        progCnt_next = (supplyLevel == FPS_SUPPLY_PROGRAM) ? progCnt_reg + 16'h0001 : 16'h0000;
        quietCnt_next = pulsing ? 16'h0000 : quietCnt_reg + 16'h0001;
        pulseCnt_next = pulsing ? pulseCnt_reg + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            progCnt_reg <= 16'h0000;
            quietCnt_reg <= 16'h0000;
            pulseCnt_reg <= 16'h0000;
        end else begin
            progCnt_reg <= progCnt_next;
            quietCnt_reg <= quietCnt_next;
            pulseCnt_reg <= pulseCnt_next;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_ONE_BIT: assert property ($onehot0(promDataOe)) else $error("two outputs pulsed");
    AST_OE_GATED: assert property (
        pulsing |-> promSelect && supplyLevel == FPS_SUPPLY_PROGRAM)
        else $error("pulse outside programming phase");
    // the timer holds each pulse one cycle past its count, so the minimum is never cut short
    AST_WIDTH: assert property ($fell(pulsing) |-> pulseCnt_reg == PULSE_CYC + 1)
        else $error("pulse width wrong");
    AST_LEVEL: assert property (pulsing |-> (promDataOut & promDataOe) == promDataOe)
        else $error("pulse not at program level");
    AST_QUIET_RISE: assert property (
        $rose(supplyLevel == FPS_SUPPLY_PROGRAM) |-> promDataOe == '0)
        else $error("outputs driven at supply rise");
    AST_FIRST_DELAY: assert property (
        $rose(pulsing) |-> progCnt_reg >= RISE_CYC + DELAY_CYC)
        else $error("pulse too soon after supply rise");
    AST_GAP: assert property ($rose(pulsing) |-> quietCnt_reg >= DELAY_CYC)
        else $error("pulses too close");
    AST_LOWER: assert property (
        $fell(supplyLevel == FPS_SUPPLY_PROGRAM) |-> quietCnt_reg >= DELAY_CYC)
        else $error("supply lowered too soon");
    AST_VERIFY: assert property (
        !promSelect |-> supplyLevel == FPS_SUPPLY_VERIFY && !pulsing)
        else $error("read back while not at verify level");
    AST_ADDR: assert property (reqValid && reqReady |=> promAddr == $past(reqWord.addr))
        else $error("address not driven");
    AST_PASS: assert property (
        doneValid && donePass |-> doneResult.actual == doneResult.desired)
        else $error("pass with mismatching data");
    AST_DONE: assert property (doneValid |=> !doneValid) else $error("done held");
endmodule
bind fps_programmer fps_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .RISE_CYC(RISE_CYC),
    .DELAY_CYC(DELAY_CYC), .PULSE_CYC(PULSE_CYC)) chk (.mclk(mclk), .resetn(resetn),
    .reqValid(reqValid), .reqReady(reqReady), .reqWord(reqWord), .doneValid(doneValid),
    .donePass(donePass), .doneResult(doneResult), .promAddr(promAddr),
    .promSelect(promSelect), .supplyLevel(supplyLevel), .promDataOut(promDataOut),
    .promDataOe(promDataOe));

/* File: fps_prom_model.sv */
module fps_prom_model #(
    parameter int PULSE_CYC = 5
) (
    input wire logic mclk,
    input wire logic [8:0] promAddr,
    input wire logic promSelect,
    input wire fps_pkg::fps_supply_e supplyLevel,
    input wire logic [7:0] promDataOut,
    input wire logic [7:0] promDataOe,
    input wire logic [7:0] slowMask,
    input wire logic [7:0] stuckMask,
    output logic [7:0] promDataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import fps_pkg::*;
    logic [7:0] mem [512];
    int hitCyc [8];
    logic [8:0] lastAddr = 9'h000;
    logic [7:0] lastRd = 8'h00;
    initial for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    // fuse time adds up per bit while the word stays addressed; slow bits need two pulses
    always @(posedge mclk) begin
        if (promAddr != lastAddr) hitCyc <= '{default: 0};
        lastAddr <= promAddr;
        lastRd <= promDataIn;
        for (int b = 0; b < 8; b++) begin
            if (supplyLevel == FPS_SUPPLY_PROGRAM && promSelect &&
                promDataOe[b] && promDataOut[b]) begin
                hitCyc[b] <= hitCyc[b] + 1;
                if (!stuckMask[b] && hitCyc[b] + 1 >= (slowMask[b] ? 2 : 1) * PULSE_CYC) begin
                    mem[promAddr][b] <= 1'b0;
                end
            end
        end
    end
    // deselected outputs float; toggling stops a stale value passing for data
    assign promDataIn = (!promSelect && supplyLevel == FPS_SUPPLY_VERIFY) ?
        mem[promAddr] : ~lastRd;
endmodule

/* File: fuse_prom_program_sequencer_tb.sv */
module fuse_prom_program_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fps_pkg::*;
    localparam int RISE = 2, DLY = 3, PLS = 5, MAXP = 3;
    logic mclk = 0, resetn = 0, reqValid = 0, reqReady, doneValid, donePass, promSelect;
    fps_word_s reqWord = '0;
    fps_result_s doneResult, r;
    fps_supply_e supplyLevel;
    logic [8:0] promAddr;
    logic [7:0] promDataOut, promDataOe, promDataIn, prevOe = 0, slowMask = 0, stuckMask = 0;
    logic p;
    int err_total = 0, check_count = 0, pulses = 0, n;
    fps_programmer #(.RISE_CYC(RISE), .DELAY_CYC(DLY), .PULSE_CYC(PLS), .MAX_PULSES(MAXP)) uut (
        .mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
        .reqWord(reqWord), .doneValid(doneValid), .donePass(donePass), .doneResult(doneResult),
        .promAddr(promAddr), .promSelect(promSelect), .supplyLevel(supplyLevel),
        .promDataOut(promDataOut), .promDataOe(promDataOe), .promDataIn(promDataIn));
    fps_prom_model #(.PULSE_CYC(PLS)) prom (.mclk(mclk), .promAddr(promAddr),
        .promSelect(promSelect), .supplyLevel(supplyLevel), .promDataOut(promDataOut),
        .promDataOe(promDataOe), .slowMask(slowMask), .stuckMask(stuckMask),
        .promDataIn(promDataIn));
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) begin
        if (|promDataOe && !(|prevOe)) pulses++;
        prevOe <= promDataOe;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // one word through the handshake; a hang counts as a mismatch
    task automatic run(input logic [8:0] a, input logic [7:0] d);
        int i;
        pulses = 0;
        reqWord <= '{addr: a, data: d};
        reqValid <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (reqReady !== 1'b1 && i < 10);
        reqValid <= 1'b0;
        if (reqReady !== 1'b1) begin
            i = 3000;
        end else begin
            for (i = 0; i < 3000 && doneValid !== 1'b1; i++) @(posedge mclk);
        end
        if (i == 3000) begin
            err_total++;
            $display("FAIL timeout addr %0h expected 1 seen 0", a);
            tally_and_finish();
        end
        p = donePass;
        r = doneResult;
        n = pulses;
    endtask
    task automatic t_blank;
        run(9'h1FF, 8'hFF);
        chk("pass", p, 1);
        chk("pulses", n, 0);
        chk("actual", r.actual, 8'hFF);
        $display("blank done");
    endtask
    task automatic t_word;
        run(9'h0A5, 8'h5A);
        chk("pass", p, 1);
        chk("pulses", n, 4);
        chk("cell", prom.mem[9'h0A5], 8'h5A);
        $display("word done");
    endtask
    task automatic t_slow;
        slowMask = 8'h01;
        run(9'h100, 8'hFE);
        chk("pass", p, 1);
        chk("pulses", n, 2);
        slowMask = 8'h00;
        $display("slow done");
    endtask
    task automatic t_reject;
        stuckMask = 8'h80;
        run(9'h003, 8'h7F);
        chk("pass", p, 0);
        chk("pulses", n, MAXP);
        chk("result", r, {9'h003, 8'h7F, 8'hFF});
        stuckMask = 8'h00;
        $display("reject done");
    endtask
    task automatic t_lost_one;
        run(9'h0A5, 8'hFF);
        chk("pass", p, 0);
        chk("pulses", n, 0);
        chk("actual", r.actual, 8'h5A);
        $display("lost one done");
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        t_blank();
        t_word();
        t_slow();
        t_reject();
        t_lost_one();
        tally_and_finish();
    end
endmodule
